// [rtl/multi_frame_receive_buffer.sv]
// multi-frame receive sequencer: sub-buffer fill, status words, frame count
`timescale 1ns/100ps
module multi_frame_receive_buffer
  import mfrb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic multi_rx_enable,
  input wire logic transceive_active,
  input wire logic idle_cmd,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_frame_end,
  input wire logic rx_crc_fail,
  input wire logic rx_collision,
  input wire logic [MFRB_ADDR_W-1:0] host_rd_addr,
  output logic [7:0] host_rd_data,
  output logic receiver_enable,
  output logic multi_frame_cycle,
  output logic rx_event,
  output logic [3:0] frames_received,
  output logic await_send_state
);

  mfrb_buf_if buf_bus ();

  mfrb_store u_store (
    .core_clk(core_clk),
    .resetn(resetn),
    .bus(buf_bus.store)
  );

  mfrb_state_t state;
  mfrb_state_t next_state;
  logic start_req;
  logic start_req_d;
  logic start_pulse;
  logic [7:0] rx_count;
  logic [7:0] len_byte;
  logic len_over;
  logic first_over;
  logic crc_seen;
  logic coll_seen;
  logic [1:0] stat_idx;
  logic [3:0] gap_cnt;
  logic [7:0] flag_byte;
  logic [7:0] stat_byte;
  logic short_frame;
  logic len_error;
  logic [MFRB_ADDR_W-1:0] sub_base;
  logic payload_wr;
  logic frame_done;
  logic stop_req;

  // ***********************************************************
  // cycle start detection
  // ***********************************************************
  // armed only on the rising edge so a finished cycle does not restart itself
  assign start_req = multi_rx_enable && transceive_active;
  assign start_pulse = start_req && !start_req_d && (state == mfrb_st_off);
  // a cycle lives only while enable and transceive both stand; idle ends it as well
  assign stop_req = idle_cmd || !start_req;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      start_req_d <= 1'b0;
    end else begin
      start_req_d <= start_req;
    end
  end

  // ***********************************************************
  // sequencer
  // ***********************************************************
  assign frame_done = (state == mfrb_st_status) && (stat_idx == MFRB_STAT_LAST);

  // next state; the idle command overrides every other transition
  always_comb begin
    next_state = state;
    case (state)
      mfrb_st_off: begin
        if (start_pulse) begin
          next_state = mfrb_st_listen;
        end
      end
      mfrb_st_listen: begin
        if (rx_frame_end) begin
          next_state = mfrb_st_status;
        end
      end
      mfrb_st_status: begin
        if (frame_done) begin
          if (frames_received + MFRB_FRAMES_ONE == MFRB_FRAMES_MAX) begin
            next_state = mfrb_st_off;
          end else begin
            next_state = mfrb_st_gap;
          end
        end
      end
      mfrb_st_gap: begin
        if (gap_cnt == MFRB_REARM_LAST) begin
          next_state = mfrb_st_listen;
        end
      end
      default: begin
        next_state = mfrb_st_off;
      end
    endcase
    // checked last so that a stop wins over a frame end or a re-arm in the same cycle
    if (stop_req) begin
      next_state = mfrb_st_off;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state <= mfrb_st_off;
    end else begin
      state <= next_state;
    end
  end

  // receiver held off through status writing and the re-arm gap
  assign receiver_enable = (state == mfrb_st_listen);
  assign multi_frame_cycle = (state != mfrb_st_off);

  // ***********************************************************
  // re-arm gap counter
  // ***********************************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      gap_cnt <= 4'h0;
    end else if (state == mfrb_st_gap) begin
      gap_cnt <= gap_cnt + 4'h1;
    end else begin
      gap_cnt <= 4'h0;
    end
  end

  // ***********************************************************
  // per-frame byte accounting
  // ***********************************************************
  // the first byte of a frame is its length byte
  assign first_over = (rx_count == MFRB_ZERO_BYTE) && (rx_byte > MFRB_LEN_MAX);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_count <= MFRB_ZERO_BYTE;
      len_byte <= MFRB_ZERO_BYTE;
      len_over <= 1'b0;
    end else if (state != mfrb_st_listen) begin
      if (state == mfrb_st_gap || start_pulse) begin
        rx_count <= MFRB_ZERO_BYTE;
        len_byte <= MFRB_ZERO_BYTE;
        len_over <= 1'b0;
      end
    end else if (rx_byte_valid) begin
      if (rx_count != MFRB_COUNT_SAT) begin
        rx_count <= rx_count + 8'h01;
      end
      if (rx_count == MFRB_ZERO_BYTE) begin
        len_byte <= rx_byte;
        len_over <= first_over;
      end
    end
  end

  // crc result is taken at the frame end, a clash at any point in the frame; both cleared per frame
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      crc_seen <= 1'b0;
      coll_seen <= 1'b0;
    end else if (state == mfrb_st_listen) begin
      if (rx_frame_end && rx_crc_fail) begin
        crc_seen <= 1'b1;
      end
      if (rx_collision) begin
        coll_seen <= 1'b1;
      end
    end else if (state == mfrb_st_gap || start_pulse) begin
      crc_seen <= 1'b0;
      coll_seen <= 1'b0;
    end
  end

  // ***********************************************************
  // status word contents
  // ***********************************************************
  assign short_frame = (rx_count < len_byte);
  assign len_error = len_over || short_frame;

  always_comb begin
    flag_byte = MFRB_ZERO_BYTE;
    flag_byte[MFRB_FLG_INTEGRITY] = crc_seen;
    flag_byte[MFRB_FLG_FRAMING] = short_frame;
    flag_byte[MFRB_FLG_COLLISION] = coll_seen;
    flag_byte[MFRB_FLG_LENGTH] = len_error;
    flag_byte[MFRB_FLG_COMBINED] = crc_seen || short_frame || coll_seen;
  end

  always_comb begin
    case (stat_idx)
      MFRB_STAT_COUNT: stat_byte = rx_count;
      MFRB_STAT_FLAGS: stat_byte = flag_byte;
      default: stat_byte = MFRB_ZERO_BYTE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stat_idx <= 2'h0;
    end else if (state == mfrb_st_status) begin
      stat_idx <= stat_idx + 2'h1;
    end else begin
      stat_idx <= 2'h0;
    end
  end

  // ***********************************************************
  // buffer write port
  // ***********************************************************
  // base comes from the count before this frame is added
  assign sub_base = {frames_received[2:0], MFRB_SUB_SHIFT'(0)};

  // over-long frames copy nothing; payload stops at 28 bytes
  assign payload_wr = (state == mfrb_st_listen) && rx_byte_valid && !first_over
                      && !len_over && (rx_count < {3'h0, MFRB_PAYLOAD_MAX});

  always_comb begin
    buf_bus.wr_en = 1'b0;
    buf_bus.wr_addr = sub_base;
    buf_bus.wr_data = rx_byte;
    if (state == mfrb_st_status) begin
      buf_bus.wr_en = 1'b1;
      buf_bus.wr_addr = sub_base | {3'h0, MFRB_STAT_BASE} | {6'h00, stat_idx};
      buf_bus.wr_data = stat_byte;
    end else if (payload_wr) begin
      buf_bus.wr_en = 1'b1;
      buf_bus.wr_addr = sub_base | {3'h0, rx_count[4:0]};
    end
  end

  assign buf_bus.rd_addr = host_rd_addr;
  assign host_rd_data = buf_bus.rd_data;

  // ***********************************************************
  // frame count, receive event and exit state
  // ***********************************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      frames_received <= 4'h0;
    end else if (start_pulse) begin
      frames_received <= 4'h0;
    end else if (frame_done && !stop_req && frames_received != MFRB_FRAMES_MAX) begin
      frames_received <= frames_received + MFRB_FRAMES_ONE;
    end
  end

  // one pulse per stored frame, when its status word is complete
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_event <= 1'b0;
    end else begin
      rx_event <= frame_done && !stop_req;
    end
  end

  // stands after the eighth frame until idle or the next cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      await_send_state <= 1'b0;
    end else if (idle_cmd || start_pulse) begin
      await_send_state <= 1'b0;
    end else if (frame_done && frames_received + MFRB_FRAMES_ONE == MFRB_FRAMES_MAX) begin
      await_send_state <= 1'b1;
    end
  end

endmodule

// [rtl/mfrb_pkg.sv]
// constants and types shared by the multi-frame receive buffer
package mfrb_pkg;

  // ***********************************************************
  // buffer geometry
  // ***********************************************************
  localparam int unsigned MFRB_ADDR_W = 8;
  localparam int unsigned MFRB_BUF_BYTES = 256;
  localparam int unsigned MFRB_SUB_SHIFT = 5;          // 32-byte sub-buffers
  localparam logic [4:0] MFRB_PAYLOAD_MAX = 5'h1C;     // 28 payload bytes
  localparam logic [7:0] MFRB_LEN_MAX = 8'h1C;         // largest legal length byte
  localparam logic [7:0] MFRB_COUNT_SAT = 8'hFF;
  localparam logic [4:0] MFRB_STAT_BASE = 5'h1C;       // status word at 28..31
  localparam logic [1:0] MFRB_STAT_LAST = 2'h3;

  // ***********************************************************
  // status word layout
  // ***********************************************************
  localparam logic [1:0] MFRB_STAT_COUNT = 2'h0;       // byte 28: received bytes
  localparam logic [1:0] MFRB_STAT_FLAGS = 2'h1;       // byte 29: error flags
  localparam int unsigned MFRB_FLG_COMBINED = 0;
  localparam int unsigned MFRB_FLG_INTEGRITY = 1;
  localparam int unsigned MFRB_FLG_FRAMING = 2;
  localparam int unsigned MFRB_FLG_COLLISION = 3;
  localparam int unsigned MFRB_FLG_LENGTH = 4;
  localparam logic [7:0] MFRB_ZERO_BYTE = 8'h00;

  // ***********************************************************
  // frame counting
  // ***********************************************************
  localparam logic [3:0] MFRB_FRAMES_MAX = 4'h8;
  localparam logic [3:0] MFRB_FRAMES_ONE = 4'h1;

  // ***********************************************************
  // receiver re-arm gap, in rf carrier cycles and core cycles
  // ***********************************************************
  localparam int unsigned MFRB_RF_FREQ_KHZ = 13560;
  localparam int unsigned MFRB_CLK_FREQ_KHZ = 10000;
  localparam int unsigned MFRB_REARM_RF_CYCLES = 2;
  localparam int unsigned MFRB_REARM_RAW =
    (MFRB_REARM_RF_CYCLES * MFRB_CLK_FREQ_KHZ + MFRB_RF_FREQ_KHZ - 1) / MFRB_RF_FREQ_KHZ;
  localparam int unsigned MFRB_REARM_CYCLES = (MFRB_REARM_RAW < 1) ? 1 : MFRB_REARM_RAW;
  localparam logic [3:0] MFRB_REARM_LAST = 4'(MFRB_REARM_CYCLES - 1);

  typedef enum logic [1:0] {
    mfrb_st_off,
    mfrb_st_listen,
    mfrb_st_status,
    mfrb_st_gap
  } mfrb_state_t;

endpackage

// [rtl/mfrb_buf_if.sv]
// write and read port bundle between the sequencer and the byte store
`timescale 1ns/100ps
interface mfrb_buf_if;
  import mfrb_pkg::*;
  logic wr_en;
  logic [MFRB_ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [MFRB_ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  modport seq (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// [rtl/mfrb_store.sv]
// 256-byte receive buffer built from flip-flops, one write and one read port
`timescale 1ns/100ps
module mfrb_store
  import mfrb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  mfrb_buf_if.store bus
);

  logic [7:0] mem [MFRB_BUF_BYTES];

  // ***********************************************************
  // storage entries
  // ***********************************************************
  // no reset on the array: contents are undefined until written, like any ram
  for (genvar i = 0; i < MFRB_BUF_BYTES; i++) begin : g_entry
    always_ff @(posedge core_clk) begin
      if (bus.wr_en && (bus.wr_addr == MFRB_ADDR_W'(i))) begin
        mem[i] <= bus.wr_data;
      end
    end
  end

  // ***********************************************************
  // registered read port
  // ***********************************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bus.rd_data <= MFRB_ZERO_BYTE;
    end else begin
      bus.rd_data <= mem[bus.rd_addr];
    end
  end

endmodule

// [verif/mfrb_host.sv]
// host-side reader of the receive buffer
`timescale 1ns/100ps
module mfrb_host
  import mfrb_pkg::*;
(
  input wire logic core_clk,
  output logic [MFRB_ADDR_W-1:0] host_rd_addr,
  input wire logic [7:0] host_rd_data
);
  // ***********
  // read access
  // ***********
  initial host_rd_addr = 8'h00;
  // data is registered, so it is taken one full cycle after the address
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    host_rd_addr = a;
    @(negedge core_clk);
    d = host_rd_data;
  endtask
  // callers read only payload and status, never the gap before status
endmodule

// [verif/mfrb_chk.sv]
// assertions on the multi-frame receive sequencer ports
`timescale 1ns/100ps
module mfrb_chk
  import mfrb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic multi_rx_enable,
  input wire logic transceive_active,
  input wire logic idle_cmd,
  input wire logic rx_frame_end,
  input wire logic receiver_enable,
  input wire logic multi_frame_cycle,
  input wire logic rx_event,
  input wire logic [3:0] frames_received,
  input wire logic await_send_state
);
  // the cycle may only go on while enable and transceive stand and idle is absent
  logic run_ok;
  assign run_ok = !idle_cmd && multi_rx_enable && transceive_active;
  // **********
  // properties
  // **********
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  listen_gate_a: assert property (receiver_enable |-> multi_frame_cycle)
    else $error("receiver on outside a cycle");
  start_clear_a: assert property ($rose(multi_frame_cycle) |-> frames_received == 4'h0
    && receiver_enable && $past(multi_rx_enable && transceive_active))
    else $error("bad cycle start");
  // status bytes plus the re-arm gap keep the receiver off for six cycles
  status_gap_a: assert property (rx_frame_end && receiver_enable |=>
    (!receiver_enable)[*6]) else $error("receiver gap too short");
  frame_event_a: assert property ((rx_frame_end && receiver_enable && run_ok)
    ##1 (run_ok)[*4] |=> rx_event) else $error("frame event late");
  event_pulse_a: assert property (rx_event |=> !rx_event)
    else $error("event longer than a cycle");
  count_step_a: assert property (rx_event |->
    frames_received == $past(frames_received) + 4'h1) else $error("count not stepped");
  count_cap_a: assert property (frames_received <= 4'h8)
    else $error("count above eight");
  rearm_a: assert property (rx_event && multi_frame_cycle && run_ok ##1 run_ok
    |=> receiver_enable) else $error("receiver not re-armed");
  eighth_exit_a: assert property (rx_event && frames_received == 4'h8 |->
    await_send_state && !multi_frame_cycle) else $error("no exit after eighth");
  idle_stop_a: assert property (idle_cmd |=>
    !receiver_enable && !multi_frame_cycle && !await_send_state) else $error("idle ignored");
  gate_drop_a: assert property (!(multi_rx_enable && transceive_active) |=>
    !multi_frame_cycle) else $error("cycle runs without enable");
  eighth_c: cover property (rx_event && frames_received == 4'h8);
  idle_c: cover property (idle_cmd && multi_frame_cycle);
  rearm_c: cover property (rx_event ##2 receiver_enable);
endmodule
bind multi_frame_receive_buffer mfrb_chk u_chk (.core_clk, .resetn, .multi_rx_enable,
  .transceive_active, .idle_cmd, .rx_frame_end, .receiver_enable, .multi_frame_cycle,
  .rx_event, .frames_received, .await_send_state);

// [verif/multi_frame_receive_buffer_bench.sv]
// self-checking bench for the multi-frame receive buffer
`timescale 1ns/100ps
module multi_frame_receive_buffer_bench;
  import mfrb_pkg::*;
  logic core_clk = 0, resetn = 0, multi_rx_enable = 0, transceive_active = 0, idle_cmd = 0;
  logic rx_byte_valid = 0, rx_frame_end = 0, rx_crc_fail = 0, rx_collision = 0;
  logic [7:0] rx_byte = 8'h00, host_rd_addr, host_rd_data, d;
  logic receiver_enable, multi_frame_cycle, rx_event, await_send_state;
  logic [3:0] frames_received;
  int errors = 0, n_tests = 0, i, j;
  // per frame: length byte, bytes sent, expected flag byte
  logic [7:0] e_len [8] = '{8'h05, 8'h04, 8'h1E, 8'h06, 8'h03, 8'h1C, 8'h02, 8'h02};
  logic [7:0] e_cnt [8] = '{8'h05, 8'h04, 8'h03, 8'h03, 8'h03, 8'h1C, 8'h02, 8'h02};
  logic [7:0] e_flg [8] = '{8'h00, 8'h03, 8'h15, 8'h15, 8'h09, 8'h00, 8'h00, 8'h00};

  always #50 core_clk = ~core_clk;
  multi_frame_receive_buffer dut (.core_clk, .resetn, .multi_rx_enable, .transceive_active,
    .idle_cmd, .rx_byte_valid, .rx_byte, .rx_frame_end, .rx_crc_fail, .rx_collision,
    .host_rd_addr, .host_rd_data, .receiver_enable, .multi_frame_cycle, .rx_event,
    .frames_received, .await_send_state);
  mfrb_host host (.core_clk, .host_rd_addr, .host_rd_data);

  // ***********
  // bench tasks
  // ***********
  task report_and_stop;
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  // w = 0 waits for the frame event, w = 1 for the receiver; bounded so a hang ends the run
  task wait_hi(input int w);
    int t;
    for (t = 0; t < 20 && (w ? receiver_enable : rx_event) !== 1'b1; t++) @(negedge core_clk);
    if ((w ? receiver_enable : rx_event) !== 1'b1) begin
      chk("timeout", 8'h00, 8'h01);
      report_and_stop;
    end
  endtask
  // frame f: length byte then tagged payload, end marker on the last byte
  task send(input int f, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      rx_byte_valid = 1;
      rx_byte = (k == 0) ? e_len[f] : {f[2:0], k[4:0]};
      rx_frame_end = (k == n - 1);
      rx_crc_fail = (f == 1);
      rx_collision = (f == 4) && (k == 0);
      @(negedge core_clk);
    end
    rx_byte_valid = 0;
    rx_frame_end = 0;
    rx_collision = 0;
    wait_hi(0);
    chk("frames", 8'(f + 1), {4'h0, frames_received});
    if (f < 7) wait_hi(1);
  endtask

  // ************
  // main program
  // ************
  initial begin
    repeat (4) @(negedge core_clk);
    resetn = 1;
    multi_rx_enable = 1;
    repeat (3) @(negedge core_clk);
    chk("no start", 8'h00, {7'h0, multi_frame_cycle});
    transceive_active = 1;
    wait_hi(1);
    chk("start count", 8'h00, {4'h0, frames_received});
    for (i = 0; i < 8; i++) send(i, e_cnt[i]);
    chk("await send", 8'h01, {7'h0, await_send_state});
    chk("cycle off", 8'h00, {7'h0, multi_frame_cycle});
    // status words first, then every stored payload byte (frame 2 stores none)
    for (i = 0; i < 8; i++) begin
      for (j = 0; j < 4; j++) begin
        host.rd(8'(32 * i + 28 + j), d);
        chk("status", (j == 0) ? e_cnt[i] : (j == 1) ? e_flg[i] : 8'h00, d);
      end
      for (j = 0; j < e_cnt[i] && i != 2; j++) begin
        host.rd(8'(32 * i + j), d);
        chk("payload", (j == 0) ? e_len[i] : {i[2:0], j[4:0]}, d);
      end
    end
    // a fresh cycle clears the count, then idle aborts it
    transceive_active = 0;
    @(negedge core_clk);
    transceive_active = 1;
    wait_hi(1);
    chk("restart count", 8'h00, {4'h0, frames_received});
    chk("await cleared", 8'h00, {7'h0, await_send_state});
    send(0, 5);
    idle_cmd = 1;
    @(negedge core_clk);
    idle_cmd = 0;
    chk("idle rx", 8'h00, {7'h0, receiver_enable});
    chk("idle cycle", 8'h00, {7'h0, multi_frame_cycle});
    // a running cycle ends as soon as the transceive sequence stops
    transceive_active = 0;
    @(negedge core_clk);
    transceive_active = 1;
    wait_hi(1);
    transceive_active = 0;
    @(negedge core_clk);
    chk("drop rx", 8'h00, {7'h0, receiver_enable});
    chk("drop cycle", 8'h00, {7'h0, multi_frame_cycle});
    report_and_stop;
  end
endmodule
